// >>> src/eppc_cfg.svh
`ifndef EPPC_CFG_SVH
`define EPPC_CFG_SVH
// register indices; byte address is four times the index
`define EPPC_IDX_PROT       14'h1035
`define EPPC_IDX_CTRL       14'h103b
`define EPPC_IDX_OPTION     14'h103f
`define EPPC_ARRAY_TAG      5'h03
// region limits inside the 512-byte array
`define EPPC_REGION1_BASE   9'h020
`define EPPC_REGION2_BASE   9'h060
`define EPPC_REGION3_BASE   9'h0e0
// control register fields
`define EPPC_PP_OTPL        5
`define EPPC_PP_BYTE        4
`define EPPC_PP_ROW         3
`define EPPC_PP_ERASE       2
`define EPPC_PP_EEL         1
`define EPPC_PP_VPP         0
// option latch fields
`define EPPC_OPT_SECDIS     3
`define EPPC_OPT_NOWD       2
`define EPPC_OPT_ROM        1
`define EPPC_OPT_EE         0
// reset values
`define EPPC_PROT_RST       5'h1f
`define EPPC_CTRL_RST       8'h01
`define EPPC_OPT_RST        4'h0
`define EPPC_ERASED_BYTE    8'hff
`define EPPC_OPT_BLANK      4'hf
// cycles after reset in which protect bits may be cleared
`define EPPC_EARLY_CYCLES   7'd64
`define EPPC_INIT_CYCLES    2'd3
`define EPPC_RESP_OKAY      2'b00
`define EPPC_RESP_DECERR    2'b11
`endif

// >>> src/eppc_pkg.sv
package eppc_pkg;
   typedef enum logic [1:0] {
      MODE_SINGLE   = 2'b00,
      MODE_EXPANDED = 2'b01,
      MODE_BOOT     = 2'b10,
      MODE_TEST     = 2'b11
   } eppc_mode_t;
   typedef enum logic [1:0] {
      SEQ_IDLE   = 2'b00,
      SEQ_ARMED  = 2'b01,
      SEQ_TARGET = 2'b10,
      SEQ_PUMP   = 2'b11
   } eppc_seq_t;
   typedef enum logic [2:0] {
      KIND_NONE   = 3'b000,
      KIND_PROT   = 3'b001,
      KIND_CTRL   = 3'b010,
      KIND_OPTION = 3'b011,
      KIND_ARRAY  = 3'b100
   } eppc_kind_t;
endpackage : eppc_pkg

// >>> src/eppc_ctrl.sv
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/100ps
`include "eppc_cfg.svh"
// Operation
// RULE_01: while eeprom latch bit is set, array leaves the memory map
// RULE_02: protect bits reset to one; clearing works only in first 64 cycles
// RULE_03: normal modes set each protect bit once; special modes freely
// RULE_04: protect register bits 7..5 read zero
// RULE_05: option-byte protect bit set blocks option program and erase
// RULE_06: four region protect bits guard 32/64/128/288-byte regions
// RULE_07: byte and row bits pick bulk, row or single-byte erase
// RULE_08: erase bit one selects erase, zero selects program/read
// RULE_09: eeprom latch bit one latches target address and data
// RULE_10: voltage bit writable only while either latch bit is one
// RULE_11: reset copies option byte into working latches driving config
// RULE_12: option byte programs like array; normal modes wait for reset
// RULE_13: option writes hit nonvolatile byte, reads return the latches
// RULE_14: option bits 7..4 read zero; mode forcing of latches at reset
// RULE_15: boot and test modes take watchdog disable from test input
// RULE_16: security disable reads one when security is not built in
// RULE_17: rom latch zero unmaps rom, single-chip keeps rom mapped
// RULE_18: eeprom enable latch zero unmaps the array to external bus
// RULE_19: security restricts the chip to single-chip modes
// RULE_20: voltage reaches array only after arm, target, then pump write
// RULE_21: one write setting both latch and voltage bits clears both
// RULE_22: otp and eeprom latch bits exclusive; otp write ignored in pump
// RULE_23: erased byte reads all ones; programming only clears bits
// RULE_24: protected targets stay unchanged and never receive voltage
module eppc_ctrl #(
   parameter int AW             = 16,
   parameter bit SECURITY_BUILT = 1'b1,
   parameter bit OTP_VARIANT    = 1'b1
) (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              nvBlank_n,
   input  wire logic [1:0]        modePins,
   input  wire logic              testWatchdogInhibit,
   input  wire logic [AW-1:0]     s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [AW-1:0]     s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   output eppc_pkg::eppc_mode_t   activeMode,
   output logic                   romMapped,
   output logic                   eepromMapped,
   output logic                   watchdogDisabled,
   output logic                   securityActive,
   output logic                   progVoltageOn
);
   import eppc_pkg::*;

   typedef struct packed {
      logic [1:0]    modeS1;
      logic [1:0]    modeS2;
      logic          inhS1;
      logic          inhS2;
      logic [1:0]    initCnt;
      eppc_mode_t    mode;
      logic [6:0]    cyc;
      logic [4:0]    protBits;
      logic [4:0]    setOnce;
      logic [7:0]    ctrlReg;
      eppc_seq_t     seq;
      logic [8:0]    tgtAddr;
      logic          tgtOpt;
      logic [7:0]    tgtData;
      logic          commit;
      logic [3:0]    optLatch;
      logic          awGot;
      logic          wGot;
      logic [AW-1:0] awAddr;
      logic [7:0]    wByte;
      logic          wLow;
      logic          awready;
      logic          wready;
      logic          arready;
      logic          bvalid;
      logic [1:0]    bresp;
      logic          rvalid;
      logic [31:0]   rdata;
      logic [1:0]    rresp;
      logic          romMap;
      logic          eeMap;
      logic          wdDis;
      logic          secAct;
      logic          pv;
   } eppc_state_t;

   eppc_state_t s_r;
   eppc_state_t s_nxt;

   // nonvolatile storage survives system reset; only a blank pulse clears it
   logic [7:0] nvArray [512];
   logic [3:0] nvOpt;
   logic       wdPrev;
   logic       tgtProt;

   function automatic eppc_kind_t kindOf(input logic [AW-1:0] a);
      logic [13:0] idx;
      idx = a[15:2];
      if (idx == `EPPC_IDX_PROT)
         return KIND_PROT;
      else if (idx == `EPPC_IDX_CTRL)
         return KIND_CTRL;
      else if (idx == `EPPC_IDX_OPTION)
         return KIND_OPTION;
      else if (idx[13:9] == `EPPC_ARRAY_TAG)
         return KIND_ARRAY;
      return KIND_NONE;
   endfunction : kindOf

   function automatic logic isProt(input logic [4:0] bp,
                                   input logic       opt,
                                   input logic [8:0] a,
                                   input logic [7:0] pp);
      logic bulk;
      bulk = pp[`EPPC_PP_ERASE] & ~pp[`EPPC_PP_BYTE] & ~pp[`EPPC_PP_ROW];
      if (opt)
         return bp[4];                                    // RULE_05
      if (bulk)
         return |bp[3:0];
      // rows never straddle a region, so the target address decides
      if (a < `EPPC_REGION1_BASE)
         return bp[0];                                    // RULE_06
      if (a < `EPPC_REGION2_BASE)
         return bp[1];
      if (a < `EPPC_REGION3_BASE)
         return bp[2];
      return bp[3];
   endfunction : isProt

   assign tgtProt = isProt(s_r.protBits, s_r.tgtOpt, s_r.tgtAddr, s_r.ctrlReg);

   always_comb begin
      logic [7:0] d;
      logic [7:0] pp;
      logic       special;
      logic       secOn;
      eppc_mode_t m;
      d       = s_r.wByte;
      pp      = s_r.ctrlReg;
      special = s_r.mode[1];
      secOn   = 1'b0;
      m       = s_r.mode;
      s_nxt   = s_r;
      s_nxt.modeS1 = modePins;
      s_nxt.modeS2 = s_r.modeS1;
      s_nxt.inhS1  = testWatchdogInhibit;
      s_nxt.inhS2  = s_r.inhS1;
      s_nxt.commit = 1'b0;
      if (s_r.cyc != `EPPC_EARLY_CYCLES)
         s_nxt.cyc = s_r.cyc + 7'd1;
      if (s_r.initCnt != 2'd0)
         s_nxt.initCnt = s_r.initCnt - 2'd1;
      // reset sequence: strap caught once synchronisers hold it
      if (s_r.initCnt == 2'd1) begin
         secOn = SECURITY_BUILT & ~nvOpt[`EPPC_OPT_SECDIS];
         m = eppc_mode_t'(s_r.modeS2);
         if (secOn)
            m = eppc_mode_t'({s_r.modeS2[1], 1'b0});      // RULE_19
         s_nxt.mode = m;
         s_nxt.optLatch = nvOpt;                          // RULE_11
         if (!SECURITY_BUILT || m[0])
            s_nxt.optLatch[`EPPC_OPT_SECDIS] = 1'b1;      // RULE_14 RULE_16
         if (m[1])
            s_nxt.optLatch[`EPPC_OPT_NOWD] = wdPrev;      // RULE_14
         if (m == MODE_SINGLE)
            s_nxt.optLatch[`EPPC_OPT_ROM] = 1'b1;         // RULE_14
      end

      // write path
      if (s_r.awready && s_axi_awvalid) begin
         s_nxt.awGot  = 1'b1;
         s_nxt.awAddr = s_axi_awaddr;
      end
      if (s_r.wready && s_axi_wvalid) begin
         s_nxt.wGot  = 1'b1;
         s_nxt.wByte = s_axi_wdata[7:0];
         s_nxt.wLow  = s_axi_wstrb[0];
      end
      if (s_r.awGot && s_r.wGot && !s_r.bvalid) begin
         s_nxt.awGot = 1'b0;
         s_nxt.wGot  = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = `EPPC_RESP_OKAY;
         case (kindOf(s_r.awAddr))
            KIND_PROT: begin
               if (s_r.wLow) begin
                  for (int i = 0; i < 5; i++) begin
                     if (special)
                        s_nxt.protBits[i] = d[i];         // RULE_03
                     else if (d[i] && !s_r.protBits[i] &&
                              !s_r.setOnce[i]) begin
                        s_nxt.protBits[i] = 1'b1;         // RULE_03
                        s_nxt.setOnce[i]  = 1'b1;
                     end else if (!d[i] &&
                                  s_r.cyc != `EPPC_EARLY_CYCLES)
                        s_nxt.protBits[i] = 1'b0;         // RULE_02
                  end
               end
            end
            KIND_CTRL: begin
               if (s_r.wLow) begin
                  pp[7:6] = d[7:6];
                  pp[4:2] = d[4:2];                       // RULE_07 RULE_08
                  if (!(s_r.ctrlReg[`EPPC_PP_OTPL] &&
                        s_r.ctrlReg[`EPPC_PP_VPP]))
                     pp[`EPPC_PP_OTPL] = OTP_VARIANT & d[5] & ~d[1]; // RULE_22
                  pp[`EPPC_PP_EEL] = d[1] & ~pp[`EPPC_PP_OTPL];      // RULE_22
                  if (d[1] && d[0] && !s_r.ctrlReg[`EPPC_PP_EEL]) begin
                     pp[`EPPC_PP_EEL] = 1'b0;             // RULE_21
                     pp[`EPPC_PP_VPP] = 1'b0;
                  end else if (s_r.ctrlReg[`EPPC_PP_OTPL] ||
                               s_r.ctrlReg[`EPPC_PP_EEL])
                     pp[`EPPC_PP_VPP] = d[0];             // RULE_10
                  s_nxt.ctrlReg = pp;
                  if (!pp[`EPPC_PP_EEL])
                     s_nxt.seq = SEQ_IDLE;
                  else if (!d[0]) begin
                     if (s_r.seq != SEQ_TARGET)
                        s_nxt.seq = SEQ_ARMED;            // RULE_20
                  end else if (s_r.seq == SEQ_TARGET && pp[`EPPC_PP_VPP]
                               && !tgtProt) begin
                     s_nxt.seq    = SEQ_PUMP;             // RULE_20 RULE_24
                     s_nxt.commit = 1'b1;
                  end
               end
            end
            KIND_OPTION, KIND_ARRAY: begin
               if (kindOf(s_r.awAddr) == KIND_ARRAY &&
                   !s_r.optLatch[`EPPC_OPT_EE])
                  s_nxt.bresp = `EPPC_RESP_DECERR;        // RULE_18
               else if (s_r.ctrlReg[`EPPC_PP_EEL] &&
                        s_r.seq == SEQ_ARMED && s_r.wLow) begin
                  s_nxt.tgtAddr = s_r.awAddr[10:2];       // RULE_09
                  s_nxt.tgtOpt  = kindOf(s_r.awAddr) == KIND_OPTION; // RULE_13
                  s_nxt.tgtData = d;
                  s_nxt.seq     = SEQ_TARGET;             // RULE_20
               end
            end
            default: s_nxt.bresp = `EPPC_RESP_DECERR;
         endcase
      end
      if (s_r.bvalid && s_axi_bready)
         s_nxt.bvalid = 1'b0;

      // read path
      if (s_r.arready && s_axi_arvalid) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp  = `EPPC_RESP_OKAY;
         s_nxt.rdata  = 32'h0000_0000;
         case (kindOf(s_axi_araddr))
            KIND_PROT:   s_nxt.rdata[4:0] = s_r.protBits; // RULE_04
            KIND_CTRL:   s_nxt.rdata[7:0] = s_r.ctrlReg;
            KIND_OPTION: s_nxt.rdata[3:0] = s_r.optLatch; // RULE_13 RULE_14
            KIND_ARRAY: begin
               if (s_r.eeMap)                             // RULE_01 RULE_18
                  s_nxt.rdata[7:0] = nvArray[s_axi_araddr[10:2]];
               else
                  s_nxt.rresp = `EPPC_RESP_DECERR;
            end
            default: s_nxt.rresp = `EPPC_RESP_DECERR;
         endcase
      end
      if (s_r.rvalid && s_axi_rready)
         s_nxt.rvalid = 1'b0;

      s_nxt.awready = s_nxt.initCnt == 2'd0 && !s_nxt.awGot && !s_nxt.bvalid;
      s_nxt.wready  = s_nxt.initCnt == 2'd0 && !s_nxt.wGot && !s_nxt.bvalid;
      s_nxt.arready = s_nxt.initCnt == 2'd0 && !s_nxt.rvalid;
      // configuration outputs come from the working latches, the mode, the synchronised test input and the eeprom latch bit
      s_nxt.romMap = s_nxt.mode == MODE_SINGLE ||
                     s_nxt.optLatch[`EPPC_OPT_ROM];       // RULE_17
      s_nxt.eeMap  = s_nxt.optLatch[`EPPC_OPT_EE] &&
                     !s_nxt.ctrlReg[`EPPC_PP_EEL];        // RULE_01 RULE_18
      s_nxt.wdDis  = s_nxt.mode[1] ? s_r.inhS2 :
                     s_nxt.optLatch[`EPPC_OPT_NOWD];      // RULE_15
      s_nxt.secAct = SECURITY_BUILT &
                     ~s_nxt.optLatch[`EPPC_OPT_SECDIS];   // RULE_19
      s_nxt.pv     = s_nxt.seq == SEQ_PUMP &&
                     s_nxt.ctrlReg[`EPPC_PP_VPP];         // RULE_20
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r          <= '0;
         s_r.initCnt  <= `EPPC_INIT_CYCLES;
         s_r.mode     <= MODE_SINGLE;
         s_r.protBits <= `EPPC_PROT_RST;                  // RULE_02
         s_r.ctrlReg  <= `EPPC_CTRL_RST;
         s_r.seq      <= SEQ_IDLE;
         s_r.optLatch <= `EPPC_OPT_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // array update: erase sets ones, programming only clears bits
   always_ff @(posedge clk or negedge nvBlank_n) begin
      if (!nvBlank_n) begin
         nvOpt  <= `EPPC_OPT_BLANK;
         wdPrev <= 1'b1;
         for (int i = 0; i < 512; i++)
            nvArray[i] <= `EPPC_ERASED_BYTE;
      end else begin
         // latch value is held while a reset sequence is in progress
         if (s_r.initCnt == 2'd0)
            wdPrev <= s_r.optLatch[`EPPC_OPT_NOWD];
         if (s_r.commit && s_r.tgtOpt) begin
            if (s_r.ctrlReg[`EPPC_PP_ERASE])
               nvOpt <= `EPPC_OPT_BLANK;                  // RULE_12
            else
               nvOpt <= nvOpt & s_r.tgtData[3:0];         // RULE_12
         end
         for (int i = 0; i < 512; i++) begin
            if (s_r.commit && !s_r.tgtOpt) begin
               if (s_r.ctrlReg[`EPPC_PP_ERASE]) begin
                  if (s_r.ctrlReg[`EPPC_PP_BYTE] ?
                      i[8:0] == s_r.tgtAddr :
                      (!s_r.ctrlReg[`EPPC_PP_ROW] ||
                       i[8:4] == s_r.tgtAddr[8:4]))       // RULE_07
                     nvArray[i] <= `EPPC_ERASED_BYTE;     // RULE_23
               end else if (i[8:0] == s_r.tgtAddr)
                  nvArray[i] <= nvArray[i] & s_r.tgtData; // RULE_23
            end
         end
      end
   end

   assign s_axi_awready    = s_r.awready;
   assign s_axi_wready     = s_r.wready;
   assign s_axi_bvalid     = s_r.bvalid;
   assign s_axi_bresp      = s_r.bresp;
   assign s_axi_arready    = s_r.arready;
   assign s_axi_rvalid     = s_r.rvalid;
   assign s_axi_rdata      = s_r.rdata;
   assign s_axi_rresp      = s_r.rresp;
   assign activeMode       = s_r.mode;
   assign romMapped        = s_r.romMap;
   assign eepromMapped     = s_r.eeMap;
   assign watchdogDisabled = s_r.wdDis;
   assign securityActive   = s_r.secAct;
   assign progVoltageOn    = s_r.pv;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // map flag and latch bit register on the same edge, so compare in-cycle
   chk_map_latch: assert property ( // RULE_01
      s_r.ctrlReg[`EPPC_PP_EEL] |-> !eepromMapped)
      else $error("array visible while latch bit set");
   chk_protect_late: assert property ( // RULE_02
      (s_r.cyc == `EPPC_EARLY_CYCLES && !s_r.mode[1]) |=>
      ((s_r.protBits & $past(s_r.protBits)) == $past(s_r.protBits)))
      else $error("protect bit cleared after early window");
   chk_pump_order: assert property ( // RULE_20
      $rose(progVoltageOn) |-> $past(s_r.seq, 2) == SEQ_TARGET)
      else $error("voltage applied without target step");
   chk_latch_excl: assert property ( // RULE_22
      !(s_r.ctrlReg[`EPPC_PP_OTPL] && s_r.ctrlReg[`EPPC_PP_EEL]))
      else $error("both latch bits set");
   chk_vpp_guard: assert property ( // RULE_10
      $rose(s_r.ctrlReg[`EPPC_PP_VPP]) |->
      $past(s_r.ctrlReg[`EPPC_PP_OTPL] | s_r.ctrlReg[`EPPC_PP_EEL]))
      else $error("voltage bit set without latch bit");
   chk_rom_single: assert property ( // RULE_17
      (s_r.initCnt == 2'd0 && s_r.mode == MODE_SINGLE) |=> romMapped)
      else $error("rom unmapped in single-chip mode");
   chk_prot_voltage: assert property ( // RULE_24
      $rose(progVoltageOn) |-> !$past(tgtProt, 2))
      else $error("voltage applied to protected target");
   chk_wd_test: assert property ( // RULE_15
      (s_r.initCnt == 2'd0 && s_r.mode[1]) |=>
      watchdogDisabled == $past(s_r.inhS2))
      else $error("watchdog disable not from test input");
endmodule : eppc_ctrl

// >>> bench/tb_top.sv
`timescale 1ns/100ps
`include "eppc_cfg.svh"
module tb_top;
   import eppc_pkg::*;
   localparam logic [15:0] PRT = {`EPPC_IDX_PROT, 2'b00};
   localparam logic [15:0] CTL = {`EPPC_IDX_CTRL, 2'b00};
   localparam logic [15:0] OPT = {`EPPC_IDX_OPTION, 2'b00};
   localparam logic [1:0]  DEC = `EPPC_RESP_DECERR;
   logic        clk = 1'b0, rst_n = 1'b1, nvBlank_n = 1'b1;
   logic [1:0]  modePins = 2'b00;
   logic        testWatchdogInhibit = 1'b0;
   logic [15:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic [31:0] s_axi_rdata, d;
   eppc_mode_t  activeMode;
   logic        romMapped, eepromMapped, watchdogDisabled;
   logic        securityActive, progVoltageOn;
   int          fail_count = 0, num_checks = 0;
   integer      seed = 32'h1a4c_fdb0;
   logic [7:0]  mem [512];
   logic [7:0]  nv = 8'hff, prot = 8'h1f, v;
   logic [3:0]  lat = 4'h0;
   int          k;
   eppc_ctrl DUT (.clk, .rst_n, .nvBlank_n, .modePins, .testWatchdogInhibit,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .activeMode, .romMapped, .eepromMapped,
      .watchdogDisabled, .securityActive, .progVoltageOn);
   always #12.5 clk = ~clk;
   task automatic cmpData(input string nm, input logic [31:0] e, g);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask : cmpData
   task automatic cmpResp(input string nm, input logic [1:0] e, g);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask : cmpResp
   task automatic conclude;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : conclude
   // master holds each channel until its own ready is seen at an edge
   task automatic wr(input logic [15:0] a, input logic [7:0] x);
      bit aw, w;
      int n;
      aw = 0;
      w = 0;
      n = 0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, x};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw && w) && n < 60) begin
         @(posedge clk);
         n++;
         if (!aw && s_axi_awready === 1'b1) begin
            aw = 1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w && s_axi_wready === 1'b1) begin
            w = 1;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (s_axi_bvalid !== 1'b1 && n < 60) begin
         @(posedge clk);
         n++;
      end
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      cmpData("write handshake", 0, n >= 60);
   endtask : wr
   task automatic rd(input logic [15:0] a);
      int n;
      n = 0;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (s_axi_arready !== 1'b1 && n < 60);
      s_axi_arvalid <= 1'b0;
      do begin
         @(posedge clk);
         n++;
      end while (s_axi_rvalid !== 1'b1 && n < 60);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      cmpData("read handshake", 0, n >= 60);
   endtask : rd
   task automatic rdc(input logic [15:0] a, input logic [7:0] e);
      rd(a);
      cmpData("register read", {24'h0, e}, d);
   endtask : rdc
   task automatic chkMem(input int n);
      rdc(16'h1800 + 16'(n * 4), mem[n]);
   endtask : chkMem
   task automatic rstSeq(input eppc_mode_t m);
      int n;
      logic [1:0] em;
      n = 0;
      @(posedge clk);
      rst_n <= 1'b0;
      modePins <= m;
      nvBlank_n <= 1'b1;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      while (s_axi_arready !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      prot = 8'h1f;
      // stored security on folds the strap to single or boot first
      em = nv[3] ? m : {m[1], 1'b0};
      lat = {em[0] | nv[3], em[1] ? lat[2] : nv[2], em == 2'b00 | nv[1],
             nv[0]};
   endtask : rstSeq
   // arm, target, pump, then release; model follows only unguarded targets
   task automatic op(input int n, input logic [7:0] c, x, input bit o);
      logic [15:0] a;
      bit          blk;
      a = o ? OPT : 16'h1800 + 16'(n * 4);
      blk = o ? prot[4] : (c[2] && c[4:3] == 2'b00) ? |prot[3:0] :
            prot[n < 32 ? 0 : n < 96 ? 1 : n < 224 ? 2 : 3];
      wr(CTL, c);
      repeat (2) @(posedge clk);
      if (!o) begin
         cmpData("array mapped", 0, eepromMapped);
         rd(a);
         cmpResp("latched read", DEC, r);
      end
      wr(a, x);
      wr(CTL, c | 8'h01);
      repeat (3) @(posedge clk);
      cmpData("voltage", !blk, progVoltageOn);
      wr(CTL, c);
      wr(CTL, 8'h00);
      if (!blk && o) nv = c[2] ? 8'hff : nv & x;
      else if (!blk) for (int i = 0; i < 512; i++)
         if (!c[2] || c[4] ? i == n : !c[3] || i / 16 == n / 16)
            mem[i] = c[2] ? 8'hff : mem[i] & x;
   endtask : op
   initial begin
      #(25 * 30000);
      cmpData("watchdog timeout", 0, 1);
      conclude();
   end
   initial begin
      for (int i = 0; i < 512; i++) mem[i] = 8'hff;
      // fall at time zero so both asynchronous clears see an edge
      rst_n <= 1'b0;
      nvBlank_n <= 1'b0;
      rstSeq(MODE_SINGLE);
      rdc(PRT, 8'h1f);
      wr(PRT, 8'he0);
      rdc(PRT, 8'h00);
      wr(PRT, 8'h01);
      rdc(PRT, 8'h01);
      rdc(CTL, `EPPC_CTRL_RST);
      rdc(OPT, {4'h0, lat});
      repeat (70) @(posedge clk);
      wr(PRT, 8'h00);
      rdc(PRT, 8'h01);
      prot = 8'h01;
      rd(16'h0000);
      cmpResp("unmapped read", DEC, r);
      wr(16'h0004, 8'h55);
      cmpResp("unmapped write", DEC, r);
      wr(CTL, 8'h03);
      rdc(CTL, 8'h00);
      wr(CTL, 8'h01);
      rdc(CTL, 8'h00);
      wr(CTL, 8'h22);
      rdc(CTL, 8'h02);
      wr(CTL, 8'h00);
      $display("test registers done");
      for (int i = 0; i < 4; i++) begin
         k = 96 + ($unsigned($random(seed)) % 416);
         v = 8'($random(seed));
         op(k, 8'h02, v, 0);
         chkMem(k);
      end
      op(64, 8'h02, 8'h5a, 0);
      op(64, 8'h02, 8'h0f, 0);
      chkMem(64);
      op(5, 8'h02, 8'h00, 0);
      chkMem(5);
      op(64, 8'h16, 8'h00, 0);
      chkMem(64);
      op(70, 8'h02, 8'h00, 0);
      op(80, 8'h02, 8'h00, 0);
      op(66, 8'h0e, 8'h00, 0);
      chkMem(70);
      chkMem(80);
      op(200, 8'h06, 8'h00, 0);
      chkMem(80);
      op(0, 8'h02, 8'h06, 1);
      rdc(OPT, {4'h0, lat});
      $display("test array done");
      rstSeq(MODE_EXPANDED);
      repeat (4) @(posedge clk);
      cmpData("mode", {30'h0, MODE_SINGLE}, {30'h0, activeMode});
      cmpData("security", 1, securityActive);
      v = 8'($random(seed));
      testWatchdogInhibit <= v[0];
      rstSeq(MODE_BOOT);
      repeat (4) @(posedge clk);
      cmpData("mode", {30'h0, MODE_BOOT}, {30'h0, activeMode});
      cmpData("watchdog", v[0], watchdogDisabled);
      cmpData("rom map", 1, romMapped);
      cmpData("array map", 0, eepromMapped);
      rdc(OPT, {4'h0, lat});
      rd(16'h1800);
      cmpResp("unmapped array", DEC, r);
      op(0, 8'h02, 8'h00, 1);
      repeat (70) @(posedge clk);
      for (int i = 0; i < 3; i++) begin
         v = i == 1 ? 8'h1f : 8'h00;
         wr(PRT, v);
         rdc(PRT, v);
      end
      prot = 8'h00;
      op(0, 8'h06, 8'h00, 1);
      testWatchdogInhibit <= !v[0];
      repeat (4) @(posedge clk);
      cmpData("watchdog", 1, watchdogDisabled);
      $display("test option done");
      conclude();
   end
endmodule : tb_top
